// ==== rtl/ref_trip_pkg.sv ====
package ref_trip_pkg;
   // word offsets on the bus
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_MIN_TRIP  = 8'h04;
   localparam logic [7:0]  ADDR_KNEE      = 8'h08;
   localparam logic [7:0]  ADDR_SLOPE1    = 8'h0C;
   localparam logic [7:0]  ADDR_SLOPE2    = 8'h10;
   localparam logic [7:0]  ADDR_HI_PICKUP = 8'h14;
   localparam logic [7:0]  ADDR_SCALE     = 8'h18;
   localparam logic [7:0]  ADDR_STATUS    = 8'h1C;
   localparam logic [7:0]  ADDR_MASK      = 8'h20;
   localparam logic [7:0]  ADDR_MEAS      = 8'h24;
   // control fields
   localparam int          CTRL_HI_MODE   = 0;
   localparam int          CTRL_SEF_EN    = 1;
   localparam int          CTRL_SENS_IN   = 2;
   localparam int          CTRL_W         = 3;
   // status and mask fields
   localparam int          ST_TRIP        = 0;
   localparam int          ST_TRANS       = 1;
   localparam int          ST_REJECT      = 2;
   localparam int          ST_W           = 3;
   // scale factor and slopes are unsigned 8.8
   localparam int          FRAC           = 8;
   localparam logic [15:0] SCALE_MIN      = 16'h000D;
   localparam logic [15:0] SCALE_MAX_STD  = 16'h0EFF;
   localparam logic [15:0] SCALE_MAX_SENS = 16'h13FF;
   // reset values
   localparam logic [2:0]  CTRL_RST       = 3'h0;
   localparam logic [15:0] MIN_TRIP_RST   = 16'h0033;
   localparam logic [15:0] KNEE_RST       = 16'h0100;
   localparam logic [15:0] SLOPE1_RST     = 16'h0000;
   localparam logic [15:0] SLOPE2_RST     = 16'h0180;
   localparam logic [15:0] HI_PICKUP_RST  = 16'h0033;
   localparam logic [15:0] SCALE_RST      = 16'h0100;
   // samples per power cycle, and rise that must be exceeded to start transient restraint
   localparam int          HOLD_DEPTH     = 8;
   localparam logic [23:0] TRANS_STEP_MIN = 24'h000080;
endpackage : ref_trip_pkg

// ==== rtl/ref_trip_top.sv ====
`timescale 1ns/100ps
// Operation
// RL1: restraint is half of largest phase magnitude plus scaled neutral magnitude.
// RL2: differential is phasor sum of three phases plus scaled neutral phasor.
// RL3: below knee, trip when differential exceeds minimum plus first slope times restraint.
// RL4: at or above knee, add first slope times knee and second slope times excess.
// RL5: neutral current is scaled by neutral to line CT primary rating ratio.
// RL6: scale accepted only within 0.05..15 standard, 0.05..20 sensitive input.
// RL7: characteristic set by minimum, knee, first slope and second slope.
// RL8: minimum and knee are in line CT units, line CT is reference.
// RL9: restraint used is maximum of restraint samples over previous power cycle.
// RL10: restraint entering the peak hold uses fundamental components only.
// RL11: a sudden restraint rise adds a transient restraint quantity.
// RL12: no transient restraint on load switching or CT saturation recovery.
// RL13: configuration selects high-impedance or biased low-impedance mode.
// RL14: CT supervision does not block high-impedance mode; scheme logic must.
// RL15: high-impedance mode trips only on measured current above its pickup.
// RL16: high-impedance mode and sensitive earth fault cannot be enabled together.
// RL17: trip evaluated each sample tick, held in one registered flag.
module ref_trip_top
   import ref_trip_pkg::*;
#(
   parameter int HOLD_N = HOLD_DEPTH
)
(
   input  wire logic               CORE_CLK_IN,
   input  wire logic               NRST_IN,
   input  wire logic               WB_CYC_IN,
   input  wire logic               WB_STB_IN,
   input  wire logic               WB_WE_IN,
   input  wire logic [7:0]         WB_ADR_IN,
   input  wire logic [3:0]         WB_SEL_IN,
   input  wire logic [31:0]        WB_DAT_IN,
   output logic      [31:0]        WB_DAT_OUT,
   output logic                    WB_ACK_OUT,
   input  wire logic               SAMPLE_TICK_IN,
   input  wire logic signed [15:0] PH_A_RE_IN,
   input  wire logic signed [15:0] PH_A_IM_IN,
   input  wire logic signed [15:0] PH_B_RE_IN,
   input  wire logic signed [15:0] PH_B_IM_IN,
   input  wire logic signed [15:0] PH_C_RE_IN,
   input  wire logic signed [15:0] PH_C_IM_IN,
   input  wire logic signed [15:0] NEUTRAL_RE_IN,
   input  wire logic signed [15:0] NEUTRAL_IM_IN,
   input  wire logic [15:0]        HI_IMP_CUR_IN,
   output logic                    TRIP_OUT,
   output logic                    HIGH_IMP_MODE_OUT,
   output logic                    SEF_ENABLE_OUT,
   output logic                    IRQ_OUT
);

   if (HOLD_N < 2 || HOLD_N > 16)
   begin : g_bad_hold
      $error("HOLD_N must lie in 2..16");
   end

   // measurement inputs come from the sampling logic on this clock, so no synchroniser
   function automatic logic [23:0] mag(input logic signed [23:0] re,
                                       input logic signed [23:0] im);
      logic [23:0] a;
      logic [23:0] b;
      a = re[23] ? 24'(-re) : 24'(re);
      b = im[23] ? 24'(-im) : 24'(im);
      // max plus 3/8 min: within a few percent, cheap and monotonic
      if (a >= b)
         return a + (b >> 2) + (b >> 3);
      else
         return b + (a >> 2) + (a >> 3);
   endfunction : mag

   function automatic logic [15:0] wr16(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  sel);
      return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction : wr16

   //////////////////////////////////////////////////////////////////////////////////
   // datapath
   logic signed [23:0] kn_re, kn_im;
   logic [23:0]        ph_mag [3];
   logic [23:0]        max_ph;
   logic [23:0]        kn_mag;
   logic [23:0]        rest_now;
   logic [23:0]        diff_now;
   logic [23:0]        win_max;
   logic [23:0]        bias_eff;
   logic [31:0]        thr;
   logic               operate;
   logic [23:0]        hist_r [HOLD_N], hist_nxt [HOLD_N];
   logic [23:0]        held_r, held_nxt;
   logic [23:0]        trans_r, trans_nxt;
   logic [23:0]        diff_r, diff_nxt;
   logic               trip_r, trip_nxt;
   logic               trans_start;
   logic [CTRL_W-1:0]  ctrl_r;
   logic [15:0]        min_trip_r, knee_r, slope1_r;
   logic [15:0]        slope2_r, hi_pickup_r, scale_r;
   always_comb
   begin
      logic signed [31:0] p_re;
      logic signed [31:0] p_im;
      logic signed [23:0] s_re;
      logic signed [23:0] s_im;
      logic [39:0]        pm;
      logic [39:0]        k1r;
      logic [39:0]        k1k;
      logic [39:0]        k2x;
      p_re = 32'(NEUTRAL_RE_IN) * $signed({1'b0, scale_r});     // see RL5
      p_im = 32'(NEUTRAL_IM_IN) * $signed({1'b0, scale_r});
      kn_re = p_re[31:8];
      kn_im = p_im[31:8];
      ph_mag[0] = mag(24'(PH_A_RE_IN), 24'(PH_A_IM_IN));         // see RL10
      ph_mag[1] = mag(24'(PH_B_RE_IN), 24'(PH_B_IM_IN));
      ph_mag[2] = mag(24'(PH_C_RE_IN), 24'(PH_C_IM_IN));
      max_ph = ph_mag[0];
      for (int i = 1; i < 3; i++)
         if (ph_mag[i] > max_ph)
            max_ph = ph_mag[i];
      pm = 40'(mag(24'(NEUTRAL_RE_IN), 24'(NEUTRAL_IM_IN))) * 40'(scale_r);
      kn_mag = pm[31:8];
      rest_now = (max_ph + kn_mag) >> 1;                        // see RL1
      s_re = 24'(PH_A_RE_IN) + 24'(PH_B_RE_IN) + 24'(PH_C_RE_IN) + kn_re;
      s_im = 24'(PH_A_IM_IN) + 24'(PH_B_IM_IN) + 24'(PH_C_IM_IN) + kn_im;
      diff_now = mag(s_re, s_im);                                // see RL2
      // window: this sample and the previous HOLD_N-1, one power cycle
      win_max = rest_now;                                        // see RL9
      for (int i = 0; i < HOLD_N - 1; i++)
         if (hist_r[i] > win_max)
            win_max = hist_r[i];
      // only a rise beyond the step starts transient restraint; falls just decay it
      trans_start = SAMPLE_TICK_IN && (rest_now > hist_r[0] + TRANS_STEP_MIN); // see RL11
      trans_nxt = trans_r;
      if (SAMPLE_TICK_IN)
      begin
         trans_nxt = trans_r >> 1;                               // see RL12
         if (trans_start && (rest_now - hist_r[0] > trans_r >> 1))
            trans_nxt = rest_now - hist_r[0];
      end
      bias_eff = win_max + trans_nxt;
      // settings in line CT units, compared as-is against the line-referred currents
      k1r = 40'(slope1_r) * 40'(bias_eff);                       // see RL7 RL8
      k1k = 40'(slope1_r) * 40'(knee_r);
      k2x = 40'(slope2_r) * 40'(bias_eff - 24'(knee_r));
      if (bias_eff < 24'(knee_r))
         thr = 32'(min_trip_r) + k1r[39:8];                      // see RL3
      else
         thr = 32'(min_trip_r) + k1k[39:8] + k2x[39:8];          // see RL4
      if (ctrl_r[CTRL_HI_MODE])                                   // see RL13
         operate = HI_IMP_CUR_IN > hi_pickup_r;                  // see RL15
      else
         operate = 32'(diff_now) > thr;
      for (int i = 0; i < HOLD_N; i++)
         hist_nxt[i] = hist_r[i];
      held_nxt = held_r;
      diff_nxt = diff_r;
      trip_nxt = trip_r;
      if (SAMPLE_TICK_IN)
      begin
         hist_nxt[0] = rest_now;
         for (int i = 1; i < HOLD_N; i++)
            hist_nxt[i] = hist_r[i-1];
         held_nxt = win_max;
         diff_nxt = diff_now;
         trip_nxt = operate;                                     // see RL17
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         for (int i = 0; i < HOLD_N; i++)
            hist_r[i] <= 24'h000000;
         held_r  <= 24'h000000;
         trans_r <= 24'h000000;
         diff_r  <= 24'h000000;
         trip_r  <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < HOLD_N; i++)
            hist_r[i] <= hist_nxt[i];
         held_r  <= held_nxt;
         trans_r <= trans_nxt;
         diff_r  <= diff_nxt;
         trip_r  <= trip_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   // register file, classic wishbone slave answering one cycle after the request
   logic [CTRL_W-1:0] ctrl_nxt;
   logic [15:0]       min_trip_nxt, knee_nxt, slope1_nxt;
   logic [15:0]       slope2_nxt, hi_pickup_nxt, scale_nxt;
   logic [ST_W-1:0]   status_r, status_nxt;
   logic [ST_W-1:0]   mask_r, mask_nxt;
   logic              ack_r, ack_nxt;
   logic [31:0]       dat_r, dat_nxt;
   always_comb
   begin
      logic              wr;
      logic              reject;
      logic [15:0]       cand;
      logic [CTRL_W-1:0] cc;
      logic [ST_W-1:0]   clr;
      wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && ack_r;
      reject = 1'b0;
      cand = wr16(scale_r, WB_DAT_IN, WB_SEL_IN);
      cc = WB_SEL_IN[0] ? WB_DAT_IN[CTRL_W-1:0] : ctrl_r;
      clr = '0;
      ctrl_nxt = ctrl_r;
      min_trip_nxt = min_trip_r;
      knee_nxt = knee_r;
      slope1_nxt = slope1_r;
      slope2_nxt = slope2_r;
      hi_pickup_nxt = hi_pickup_r;
      scale_nxt = scale_r;
      mask_nxt = mask_r;
      if (wr)
      begin
         case (WB_ADR_IN)
            ADDR_CTRL:
            begin
               // refusing keeps the old mode rather than guessing which bit won
               if ((cc[CTRL_HI_MODE] && cc[CTRL_SEF_EN]) ||                // see RL16
                   (!cc[CTRL_SENS_IN] && scale_r > SCALE_MAX_STD))        // see RL6
                  reject = 1'b1;
               else
                  ctrl_nxt = cc;
            end
            ADDR_MIN_TRIP:  min_trip_nxt = wr16(min_trip_r, WB_DAT_IN, WB_SEL_IN);
            ADDR_KNEE:      knee_nxt = wr16(knee_r, WB_DAT_IN, WB_SEL_IN);
            ADDR_SLOPE1:    slope1_nxt = wr16(slope1_r, WB_DAT_IN, WB_SEL_IN);
            ADDR_SLOPE2:    slope2_nxt = wr16(slope2_r, WB_DAT_IN, WB_SEL_IN);
            ADDR_HI_PICKUP: hi_pickup_nxt = wr16(hi_pickup_r, WB_DAT_IN, WB_SEL_IN);
            ADDR_SCALE:
            begin
               if (cand < SCALE_MIN ||                                     // see RL6
                   cand > (ctrl_r[CTRL_SENS_IN] ? SCALE_MAX_SENS : SCALE_MAX_STD))
                  reject = 1'b1;
               else
                  scale_nxt = cand;
            end
            ADDR_STATUS:    clr = WB_SEL_IN[0] ? WB_DAT_IN[ST_W-1:0] : '0;
            ADDR_MASK:      mask_nxt = WB_SEL_IN[0] ? WB_DAT_IN[ST_W-1:0] : mask_r;
            default:        reject = 1'b0;
         endcase
      end
      // a set in the clearing cycle wins
      status_nxt = status_r & ~clr;
      status_nxt[ST_TRIP] = status_nxt[ST_TRIP] | (trip_nxt & ~trip_r);
      status_nxt[ST_TRANS] = status_nxt[ST_TRANS] | trans_start;
      status_nxt[ST_REJECT] = status_nxt[ST_REJECT] | reject;
      ack_nxt = WB_CYC_IN && WB_STB_IN && !ack_r;
      dat_nxt = dat_r;
      if (ack_nxt)
      begin
         case (WB_ADR_IN)
            ADDR_CTRL:      dat_nxt = 32'(ctrl_r);
            ADDR_MIN_TRIP:  dat_nxt = 32'(min_trip_r);
            ADDR_KNEE:      dat_nxt = 32'(knee_r);
            ADDR_SLOPE1:    dat_nxt = 32'(slope1_r);
            ADDR_SLOPE2:    dat_nxt = 32'(slope2_r);
            ADDR_HI_PICKUP: dat_nxt = 32'(hi_pickup_r);
            ADDR_SCALE:     dat_nxt = 32'(scale_r);
            ADDR_STATUS:    dat_nxt = {trip_r, 28'h0000000, status_r};
            ADDR_MASK:      dat_nxt = 32'(mask_r);
            // saturated to 16 bits each for a single-word snapshot
            ADDR_MEAS:      dat_nxt = {(|held_r[23:16]) ? 16'hFFFF : held_r[15:0],
                                       (|diff_r[23:16]) ? 16'hFFFF : diff_r[15:0]};
            default:        dat_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         ctrl_r      <= CTRL_RST;
         min_trip_r  <= MIN_TRIP_RST;
         knee_r      <= KNEE_RST;
         slope1_r    <= SLOPE1_RST;
         slope2_r    <= SLOPE2_RST;
         hi_pickup_r <= HI_PICKUP_RST;
         scale_r     <= SCALE_RST;
         status_r    <= '0;
         mask_r      <= '0;
         ack_r       <= 1'b0;
         dat_r       <= 32'h00000000;
      end
      else
      begin
         ctrl_r      <= ctrl_nxt;
         min_trip_r  <= min_trip_nxt;
         knee_r      <= knee_nxt;
         slope1_r    <= slope1_nxt;
         slope2_r    <= slope2_nxt;
         hi_pickup_r <= hi_pickup_nxt;
         scale_r     <= scale_nxt;
         status_r    <= status_nxt;
         mask_r      <= mask_nxt;
         ack_r       <= ack_nxt;
         dat_r       <= dat_nxt;
      end
   end

   assign WB_ACK_OUT        = ack_r;
   assign WB_DAT_OUT        = dat_r;
   assign TRIP_OUT          = trip_r;
   // supervision blocking of high-impedance trips is left to scheme logic outside
   assign HIGH_IMP_MODE_OUT = ctrl_r[CTRL_HI_MODE];      // see RL14
   assign SEF_ENABLE_OUT    = ctrl_r[CTRL_SEF_EN];
   assign IRQ_OUT           = |(status_r & mask_r);

   //////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   restraint_sample_a: assert property (SAMPLE_TICK_IN |=> hist_r[0] == // see RL1
      ($past(max_ph) + $past(kn_mag)) >> 1) else $error("restraint sample wrong");
   peak_hold_a: assert property (SAMPLE_TICK_IN |=> held_r >= hist_r[0] && // see RL9
      held_r >= hist_r[1]) else $error("held restraint below a window sample");
   trip_hold_a: assert property (!SAMPLE_TICK_IN |=> $stable(trip_r)) // see RL17
      else $error("trip changed off tick");
   scale_range_a: assert property (scale_r >= SCALE_MIN && scale_r <= // see RL6
      (ctrl_r[CTRL_SENS_IN] ? SCALE_MAX_SENS : SCALE_MAX_STD)) else $error("scale out of range");
   mode_excl_a: assert property (!(HIGH_IMP_MODE_OUT && SEF_ENABLE_OUT)) // see RL16
      else $error("high-impedance and sef both on");
   hi_pickup_a: assert property (SAMPLE_TICK_IN && ctrl_r[CTRL_HI_MODE] && // see RL15
      HI_IMP_CUR_IN > hi_pickup_r |=> TRIP_OUT ##1 (TRIP_OUT || $past(SAMPLE_TICK_IN)))
      else $error("high-impedance trip missed");
   low_slope_a: assert property (SAMPLE_TICK_IN && !ctrl_r[CTRL_HI_MODE] && // see RL3
      bias_eff < 24'(knee_r) && 32'(diff_now) <= 32'(min_trip_r) |=> !TRIP_OUT)
      else $error("trip below minimum threshold");
   trans_fall_a: assert property (SAMPLE_TICK_IN && rest_now <= hist_r[0] |=> // see RL12
      trans_r == $past(trans_r) >> 1) else $error("transient restraint on falling restraint");
   bus_ack_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT ##1
      !WB_ACK_OUT) else $error("ack not a single cycle");
endmodule : ref_trip_top

// ==== testbench/ct_source.sv ====
`timescale 1ns/100ps
module ct_source
(
   input  wire logic               clk_in,
   output logic                    tick_out,
   output logic signed [15:0]      re_out [4],
   output logic signed [15:0]      im_out [4],
   output logic        [15:0]      hi_out
);
   logic signed [15:0] amp [4];
   logic        [15:0] hi_amp;
   logic               quad;
   ////////////////////////////////////////////////////////////
   // off-tick values are scrambled: the block must not look at them
   task automatic drive(input logic live);
      for (int i = 0; i < 4; i++)
      begin
         re_out[i] <= !live ? ~amp[i] : (quad ? 16'sh0000 : amp[i]);
         im_out[i] <= !live ? ~amp[i] : (quad ? amp[i] : 16'sh0000);
      end
      hi_out <= live ? hi_amp : ~hi_amp;
   endtask : drive
   task automatic set_amp(input logic signed [15:0] a, b, c, n);
      amp[0] = a;
      amp[1] = b;
      amp[2] = c;
      amp[3] = n;
   endtask : set_amp
   task automatic pulse(input int n);
      repeat (n)
      begin
         @(posedge clk_in);
         tick_out <= 1'b1;
         drive(1'b1);
         @(posedge clk_in);
         tick_out <= 1'b0;
         drive(1'b0);
      end
      #1;
   endtask : pulse
   initial
   begin
      tick_out = 1'b0;
      quad     = 1'b0;
      hi_amp   = 16'h0000;
      amp      = '{default: 16'sh0000};
      re_out   = '{default: 16'sh0000};
      im_out   = '{default: 16'sh0000};
      hi_out   = 16'h0000;
   end
endmodule : ct_source

// ==== testbench/biased_earth_fault_trip_logic_tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_count++; \
   $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module biased_earth_fault_trip_logic_tb
   import ref_trip_pkg::*;
;
   localparam int      HN = 4;
   logic               clk, rst_n, cyc, stb, we, ack, trip, himode, sensitive_earth_fault, irq, tick;
   logic [7:0]         adr;
   logic [3:0]         sel, lanes;
   logic [31:0]        wdat, rdat, q;
   logic signed [15:0] re [4];
   logic signed [15:0] im [4];
   logic [15:0]        hi;
   int                 err_count, cmp_count;
   always #4 clk = ~clk;
   ct_source src (.clk_in(clk), .tick_out(tick), .re_out(re), .im_out(im), .hi_out(hi));
   ref_trip_top #(.HOLD_N(HN)) dut (
      .CORE_CLK_IN(clk), .NRST_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .SAMPLE_TICK_IN(tick),
      .PH_A_RE_IN(re[0]), .PH_A_IM_IN(im[0]), .PH_B_RE_IN(re[1]), .PH_B_IM_IN(im[1]),
      .PH_C_RE_IN(re[2]), .PH_C_IM_IN(im[2]), .NEUTRAL_RE_IN(re[3]),
      .NEUTRAL_IM_IN(im[3]), .HI_IMP_CUR_IN(hi), .TRIP_OUT(trip),
      .HIGH_IMP_MODE_OUT(himode), .SEF_ENABLE_OUT(sensitive_earth_fault), .IRQ_OUT(irq));
   ////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= lanes;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      `CHK("ack", 1'b1, ack)
      #1;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, e, input string nm);
      xfer(1'b0, a, 32'h0);
      `CHK(nm, e, q & m)
   endtask : rdc
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0]  a [10] = '{ADDR_CTRL, ADDR_MIN_TRIP, ADDR_KNEE, ADDR_SLOPE1, ADDR_SLOPE2,
                              ADDR_HI_PICKUP, ADDR_SCALE, ADDR_STATUS, ADDR_MASK, 8'h40};
      logic [31:0] e [10] = '{{29'h0, CTRL_RST}, {16'h0, MIN_TRIP_RST}, {16'h0, KNEE_RST},
                              {16'h0, SLOPE1_RST}, {16'h0, SLOPE2_RST}, {16'h0, HI_PICKUP_RST},
                              {16'h0, SCALE_RST}, 32'h0, 32'h0, 32'h0};
      `CHK("idle outputs", 4'h0, {trip, himode, sensitive_earth_fault, irq})
      for (int i = 0; i < 10; i++)
         rdc(a[i], 32'hFFFFFFFF, e[i], "reset value");
      // low lane only: the upper byte must keep its old value
      lanes = 4'h1;
      wr(ADDR_KNEE, 32'hFFFF);
      lanes = 4'h3;
      rdc(ADDR_KNEE, 32'hFFFF, {16'h0, KNEE_RST[15:8], 8'hFF}, "lane write");
      wr(ADDR_KNEE, {16'h0, KNEE_RST});
      $display("test reset done");
   endtask : t_reset
   task automatic t_scale();
      logic [15:0] v [6] = '{16'h000C, 16'h000D, 16'h0EFF, 16'h0F00, 16'h13FF, 16'h1400};
      logic [5:0]  sens = 6'b110000;
      logic [5:0]  ok = 6'b010110;
      logic [31:0] prev;
      wr(ADDR_MASK, 32'h4);
      for (int i = 0; i < 6; i++)
      begin
         wr(ADDR_CTRL, {29'h0, sens[i], 2'b00});
         wr(ADDR_STATUS, 32'h7);
         xfer(1'b0, ADDR_SCALE, 32'h0);
         prev = q;
         wr(ADDR_SCALE, {16'h0, v[i]});
         rdc(ADDR_SCALE, 32'hFFFF, ok[i] ? {16'h0, v[i]} : prev, "scale");
         rdc(ADDR_STATUS, 32'h4, {29'h0, !ok[i], 2'b00}, "reject flag");
         `CHK("irq", !ok[i], irq)
      end
      wr(ADDR_CTRL, 32'h0);
      rdc(ADDR_CTRL, 32'h7, 32'h4, "ctrl");
      wr(ADDR_MASK, 32'h0);
      wr(ADDR_CTRL, 32'h3);
      rdc(ADDR_CTRL, 32'h7, 32'h4, "ctrl");
      `CHK("masked irq", 1'b0, irq)
      wr(ADDR_MASK, 32'h4);
      `CHK("irq", 1'b1, irq)
      wr(ADDR_STATUS, 32'h4);
      `CHK("irq", 1'b0, irq)
      wr(ADDR_SCALE, 32'h100);
      wr(ADDR_CTRL, 32'h0);
      $display("test scale done");
   endtask : t_scale
   task automatic t_low();
      src.set_amp(0, 0, 0, 0);
      src.pulse(HN + 1);
      wr(ADDR_STATUS, 32'h7);
      wr(ADDR_MASK, 32'h1);
      src.set_amp(16'sh0040, 0, 0, 0);
      src.pulse(1);
      `CHK("trip", 1'b1, trip)
      rdc(ADDR_STATUS, 32'h1, 32'h1, "trip flag");
      `CHK("irq", 1'b1, irq)
      wr(ADDR_SLOPE1, 32'h80);
      src.pulse(1);
      `CHK("trip", 1'b0, trip)
      src.set_amp(16'sh0048, 0, 0, 0);
      src.pulse(1);
      `CHK("trip", 1'b1, trip)
      src.quad = 1'b1;
      src.set_amp(16'sh0044, 0, 0, 0);
      src.pulse(1);
      `CHK("trip", 1'b0, trip)
      src.set_amp(16'sh0048, 0, 0, 0);
      src.pulse(1);
      `CHK("trip", 1'b1, trip)
      src.quad = 1'b0;
      wr(ADDR_SLOPE1, 32'h0);
      wr(ADDR_STATUS, 32'h7);
      wr(ADDR_MASK, 32'h0);
      $display("test low bias done");
   endtask : t_low
   task automatic t_phasor();
      // second pass puts every phasor on the imaginary axis
      for (int k = 0; k < 2; k++)
      begin
         src.quad = (k == 1);
         src.set_amp(16'sh0100, -16'sh0100, 0, 0);
         src.pulse(1);
         rdc(ADDR_MEAS, 32'hFFFF, 32'h0, "differential");
         wr(ADDR_SCALE, 32'h200);
         src.set_amp(16'sh0100, 0, 16'sh0100, -16'sh0100);
         src.pulse(1);
         rdc(ADDR_MEAS, 32'hFFFFFFFF, 32'h01800000, "scaled meas");
         wr(ADDR_SCALE, 32'h100);
      end
      src.quad = 1'b0;
      $display("test phasor done");
   endtask : t_phasor
   task automatic t_knee();
      src.set_amp(0, 0, 0, 0);
      src.pulse(16);
      wr(ADDR_STATUS, 32'h7);
      // restraint climbs by exactly the trigger step, so no boost
      for (int i = 1; i <= 4; i++)
      begin
         src.set_amp(16'(i * 128), 0, 0, -16'(i * 128));
         src.pulse(1);
      end
      src.pulse(16);
      rdc(ADDR_STATUS, 32'h2, 32'h0, "transient flag");
      src.set_amp(16'sh02D9, 0, 0, -16'sh0127);
      src.pulse(1);
      `CHK("trip", 1'b0, trip)
      src.set_amp(16'sh02DA, 0, 0, -16'sh0126);
      src.pulse(1);
      `CHK("trip", 1'b1, trip)
      src.set_amp(16'sh01A0, 0, 0, 0);
      for (int i = 1; i <= HN; i++)
      begin
         src.pulse(1);
         `CHK("held trip", i == HN, trip)
      end
      rdc(ADDR_MEAS, 32'hFFFFFFFF, 32'h00D001A0, "meas");
      $display("test knee done");
   endtask : t_knee
   task automatic t_trans();
      src.set_amp(0, 0, 0, 0);
      src.pulse(16);
      wr(ADDR_STATUS, 32'h7);
      src.set_amp(16'sh0300, 0, 0, -16'sh0100);
      src.pulse(1);
      `CHK("trip", 1'b0, trip)
      rdc(ADDR_STATUS, 32'h2, 32'h2, "transient flag");
      src.pulse(16);
      `CHK("trip", 1'b1, trip)
      $display("test transient done");
   endtask : t_trans
   task automatic t_hiimp();
      // biased currents left at a tripping level: mode must ignore them
      wr(ADDR_CTRL, 32'h1);
      // scheme logic outside uses this pin to block on ct supervision
      `CHK("mode", 1'b1, himode)
      src.hi_amp = 16'h0033;
      src.pulse(1);
      `CHK("trip", 1'b0, trip)
      src.hi_amp = 16'h0034;
      src.pulse(1);
      `CHK("trip", 1'b1, trip)
      wr(ADDR_STATUS, 32'h7);
      wr(ADDR_CTRL, 32'h3);
      rdc(ADDR_CTRL, 32'h7, 32'h1, "ctrl");
      rdc(ADDR_STATUS, 32'h4, 32'h4, "reject flag");
      wr(ADDR_CTRL, 32'h2);
      `CHK("mode pins", 2'b01, {himode, sensitive_earth_fault})
      wr(ADDR_CTRL, 32'h0);
      $display("test high impedance done");
   endtask : t_hiimp
   ////////////////////////////////////////////////////////////
   initial
   begin
      #400000;
      err_count++;
      finish_test();
   end
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      lanes = 4'h3;
      wdat = 32'h0;
      err_count = 0;
      cmp_count = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_scale();
      t_low();
      t_phasor();
      t_knee();
      t_trans();
      t_hiimp();
      finish_test();
   end
endmodule : biased_earth_fault_trip_logic_tb
